// ---- verilog/cep_params.svh ----
// Constants for the core event priority controller
`ifndef CEP_PARAMS_SVH
`define CEP_PARAMS_SVH

`define CEP_LEVELS 16
`define CEP_LVL_W 4
`define CEP_GEN_COUNT 9
`define CEP_ADDR_W 32
`define CEP_LVL_EMUL 4'h0
`define CEP_LVL_RESET 4'h1
`define CEP_LVL_NMI 4'h2
`define CEP_LVL_EXCEPT 4'h3
`define CEP_LVL_RSVD 4'h4
`define CEP_LVL_HWERR 4'h5
`define CEP_LVL_TIMER 4'h6
`define CEP_LVL_GEN_FIRST 4'h7
`define CEP_LATCH_RST 16'h0000
`define CEP_ALWAYS_ON 16'h000f
`define CEP_RSVD_FIELD 16'h0010
`define CEP_LOCAL_FIELD 16'h0060
`define CEP_GEN_FIELD 16'hff80
`define CEP_ADDR_RST 32'h00000000

`endif

// ---- verilog/cep_pkg.sv ----
// Types shared by the core event priority controller
package cep_pkg;
	typedef logic [3:0] cep_level_t;
	typedef logic [15:0] cep_vec_t;
	typedef logic [31:0] cep_addr_t;
	typedef struct packed {
		logic found;
		cep_level_t level;
	} cep_pick_t;
endpackage

// ---- verilog/cep_ret_store.sv ----
// Return-address store, one word per event level, registered read
`timescale 1ns/100ps
`include "cep_params.svh"
module cep_ret_store
	import cep_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wr_en,
	input wire cep_level_t wr_idx,
	input wire cep_addr_t wr_data,
	input wire logic rd_en,
	input wire cep_level_t rd_idx,
	output cep_addr_t rd_data
);
	cep_addr_t mem [0:15];

	// Array has no reset; a level never entered returns whatever is stored
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_data <= `CEP_ADDR_RST;
		end else if (rd_en) begin
			rd_data <= mem[rd_idx];
		end
	end
endmodule // cep_ret_store

// ---- verilog/cep_core_event_ctrl.sv ----
// Core event priority controller: latch, mask, nest and present core events
`timescale 1ns/100ps
`include "cep_params.svh"

// Behaviour
// (RULE1) General inputs are driven directly by the system interrupt router.
// (RULE2) Nine general interrupt levels, numbered 7 through 15, besides dedicated events.
// (RULE3) Software should keep levels 14 and 15 for software-raised interrupts.
// (RULE4) Fixed priority, lower number wins: emulation 0, reset 1, NMI 2, exception 3.
// (RULE5) Level 4 has no source; hardware error is 5, core timer is 6.
// (RULE6) Each general interrupt's priority equals its index; 7 ranks highest.
// (RULE7) Each level keeps its own return address; entry pushes processor state.
// (RULE8) Latch bit sets on capture, clears on acceptance or software cancel; here cancel only clears levels whose effective enable is clear.
// (RULE9) Cleared enable bit blocks servicing while the event stays latched; here enable bits 0-3 are ignored, so levels 0-3 are always serviced.
// (RULE10) Among unmasked latched events, smallest priority number is presented.
module cep_core_event_ctrl
	import cep_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic emulation_event,
	input wire logic reset_event,
	input wire logic nmi_event,
	input wire logic exception_event,
	input wire logic hw_error_event,
	input wire logic core_timer_event,
	input wire logic [8:0] general_irq_level,
	input wire cep_vec_t event_enable_bits,
	input wire logic gen_irq_global_enable,
	input wire logic latch_cancel_valid,
	input wire cep_vec_t latch_cancel_bits,
	input wire logic event_accept,
	input wire cep_addr_t save_addr,
	input wire logic return_req,
	input wire cep_level_t return_level,
	output logic event_req,
	output cep_level_t event_level,
	output cep_vec_t event_latch_bits,
	output cep_vec_t in_service_bits,
	output logic state_push,
	output cep_addr_t return_addr,
	output logic return_valid
);
	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic cep_pick_t pick_lowest(input cep_vec_t v);
		cep_pick_t p;
		p.found = 1'b0;
		p.level = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				p.found = 1'b1;
				p.level = 4'(i);
			end
		end
		return p;
	endfunction

	function automatic cep_vec_t onehot(input cep_level_t l);
		return 16'h0001 << l;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Sources, enables, pending

	cep_vec_t src_vec;
	cep_vec_t enable_eff;
	cep_vec_t pending;
	cep_vec_t allowed;
	cep_vec_t accept_clr;
	cep_vec_t cancel_clr;
	cep_pick_t svc_top;
	cep_pick_t win;
	logic accept_now;

	always_comb begin
		src_vec = 16'h0000;
		src_vec[`CEP_LVL_EMUL] = emulation_event; // [RULE4]
		src_vec[`CEP_LVL_RESET] = reset_event; // [RULE4]
		src_vec[`CEP_LVL_NMI] = nmi_event; // [RULE4]
		src_vec[`CEP_LVL_EXCEPT] = exception_event; // [RULE4]
		src_vec[`CEP_LVL_HWERR] = hw_error_event; // [RULE5]
		src_vec[`CEP_LVL_TIMER] = core_timer_event; // [RULE5]
		src_vec[15:7] = general_irq_level; // [RULE1] [RULE2] [RULE6]
	end

	// Levels 0-3 cannot be masked; level 4 never enables
	always_comb begin
		enable_eff = `CEP_ALWAYS_ON | (event_enable_bits & `CEP_LOCAL_FIELD); // [RULE9] [RULE5]
		if (gen_irq_global_enable) begin
			enable_eff = enable_eff | (event_enable_bits & `CEP_GEN_FIELD); // [RULE9]
		end
	end

	assign pending = event_latch_bits & enable_eff; // [RULE9]
	assign svc_top = pick_lowest(in_service_bits);

	// Only a level above the one being serviced may interrupt it
	always_comb begin
		allowed = pending;
		if (svc_top.found) begin
			allowed = pending & ~(16'hffff << svc_top.level);
		end
	end

	assign win = pick_lowest(allowed); // [RULE10]
	assign accept_now = event_accept && event_req;
	assign accept_clr = accept_now ? onehot(event_level) : 16'h0000;
	// Cancel only reaches events whose effective enable is clear (never levels 0-3), so a live event is never lost
	assign cancel_clr = latch_cancel_valid ? (latch_cancel_bits & ~enable_eff) : 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// Latch bits

	cep_vec_t next_latch;

	// A new capture wins over a clear in the same cycle
	always_comb begin
		next_latch = ((event_latch_bits & ~(accept_clr | cancel_clr)) | src_vec); // [RULE8]
		next_latch = next_latch & ~`CEP_RSVD_FIELD; // [RULE5]
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			event_latch_bits <= `CEP_LATCH_RST;
		end else begin
			event_latch_bits <= next_latch; // [RULE8]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Presentation to the core

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			event_req <= 1'b0;
			event_level <= 4'h0;
		end else begin
			// Drop for one cycle after acceptance so the stale winner is not taken twice
			event_req <= win.found && !accept_now; // [RULE10]
			event_level <= win.level; // [RULE10]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Nesting and return

	cep_vec_t next_service;

	always_comb begin
		next_service = in_service_bits;
		if (return_req) begin
			next_service = next_service & ~onehot(return_level);
		end
		next_service = next_service | accept_clr; // [RULE7]
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			in_service_bits <= 16'h0000;
			state_push <= 1'b0;
			return_valid <= 1'b0;
		end else begin
			in_service_bits <= next_service;
			state_push <= accept_now; // [RULE7]
			return_valid <= return_req; // [RULE7]
		end
	end

	cep_ret_store u_ret_store (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(accept_now),
		.wr_idx(event_level),
		.wr_data(save_addr),
		.rd_en(return_req),
		.rd_idx(return_level),
		.rd_data(return_addr)
	); // [RULE7]

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	chk_rsvd_empty: assert property (@(posedge clk_sys) disable iff (rst) // [RULE5]
		!event_latch_bits[4] && !(event_req && event_level == `CEP_LVL_RSVD))
		else $error("Reserved level latched or presented");

	// An accept in flight or level 0 already in service holds the request back legally
	chk_emu_capture: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
		emulation_event && !accept_now && !in_service_bits[0]
		|=> event_latch_bits[0]
		##1 ((event_req && event_level == `CEP_LVL_EMUL) || $past(accept_now)))
		else $error("Emulation event not captured and presented");

	chk_gen_map: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
		general_irq_level[0] |=> event_latch_bits[7])
		else $error("General input 0 not latched at level 7");

	chk_gen_top: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
		general_irq_level[8] |=> event_latch_bits[15])
		else $error("General input 8 not latched at level 15");

	// Judged against the raw enable ports, so a broken enable decode is caught
	chk_win_enabled: assert property (@(posedge clk_sys) disable iff (rst) // [RULE9]
		win.found |-> event_latch_bits[win.level]
		&& (win.level < `CEP_LVL_RSVD || (event_enable_bits[win.level]
		&& (win.level < `CEP_LVL_GEN_FIRST || gen_irq_global_enable))))
		else $error("Masked or unlatched event chosen");

	chk_win_lowest: assert property (@(posedge clk_sys) disable iff (rst) // [RULE10]
		win.found |-> (allowed & ~(16'hffff << win.level)) == 16'h0000)
		else $error("Winner is not the smallest priority number");

	chk_accept_clear: assert property (@(posedge clk_sys) disable iff (rst) // [RULE8]
		accept_now && !src_vec[event_level] |=> !event_latch_bits[$past(event_level)])
		else $error("Accepted event still latched");

	chk_req_drop: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
		accept_now |=> !event_req && state_push && in_service_bits[$past(event_level)])
		else $error("Accept did not push state or drop request");

	chk_cancel_masked: assert property (@(posedge clk_sys) disable iff (rst) // [RULE8]
		latch_cancel_valid && latch_cancel_bits[9] && !event_enable_bits[9]
		&& !general_irq_level[2] |=> !event_latch_bits[9])
		else $error("Cancel of masked level 9 ignored");

	chk_return_addr: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
		return_req |=> return_valid && (!in_service_bits[$past(return_level)]
		|| ($past(accept_now) && $past(event_level) == $past(return_level))))
		else $error("Return did not end service or give address");
endmodule // cep_core_event_ctrl

// ---- verification/cep_core_model.sv ----
// Core sequencer model: accepts presented events and hands over return addresses
`timescale 1ns/100ps
module cep_core_model
	import cep_pkg::*;
(
	input wire logic clk_sys,
	input wire logic accept_en,
	input wire logic event_req,
	input wire cep_level_t event_level,
	output logic event_accept,
	output cep_addr_t save_addr
);
	initial begin
		event_accept = 1'b0;
		save_addr = 32'h00000000;
	end
	////////////////////////////////////////
	// Never two accepts in a row: the request drops for a cycle after each one
	always @(negedge clk_sys) begin
		event_accept <= accept_en && event_req && !event_accept;
		save_addr <= 32'h5a000000 + 32'(event_level);
	end
endmodule // cep_core_model

// ---- verification/testbench.sv ----
// Self-checking bench for the core event priority controller
`timescale 1ns/100ps
module testbench;
	import cep_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	cep_vec_t src = 16'h0000;
	cep_vec_t en_bits = 16'hffff;
	logic gie = 1'b1;
	logic cv = 1'b0;
	cep_vec_t cbits = 16'h0000;
	logic ret_req = 1'b0;
	cep_level_t ret_lvl = 4'h0;
	logic acc_en = 1'b0;
	logic acc;
	cep_addr_t save;
	logic ereq;
	cep_level_t elvl;
	cep_vec_t latch;
	cep_vec_t insvc;
	logic push;
	cep_addr_t raddr;
	logic rvalid;
	int error_cnt = 0;
	int check_count = 0;
	always #5 clk_sys = ~clk_sys;
	// General inputs come straight from the router side, one bit per level
	cep_core_event_ctrl cep_core_event_ctrl_i (.clk_sys(clk_sys), .rst(rst),
		.emulation_event(src[0]), .reset_event(src[1]), .nmi_event(src[2]),
		.exception_event(src[3]), .hw_error_event(src[5]),
		.core_timer_event(src[6]), .general_irq_level(src[15:7]),
		.event_enable_bits(en_bits), .gen_irq_global_enable(gie),
		.latch_cancel_valid(cv), .latch_cancel_bits(cbits), .event_accept(acc),
		.save_addr(save), .return_req(ret_req), .return_level(ret_lvl),
		.event_req(ereq), .event_level(elvl), .event_latch_bits(latch),
		.in_service_bits(insvc), .state_push(push), .return_addr(raddr),
		.return_valid(rvalid));
	cep_core_model cep_core_model_i (.clk_sys(clk_sys), .accept_en(acc_en),
		.event_req(ereq), .event_level(elvl), .event_accept(acc), .save_addr(save));
	////////////////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic wrap_up();
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Cancel cannot drop latched unmaskable events, so reset clears them and any unaccepted latch between cases
	task automatic do_reset();
		rst <= 1'b1;
		src <= 16'h0000;
		cyc(20);
		rst <= 1'b0;
		cyc(1);
	endtask
	////////////////////////////////////////
	// One level alone: present, accept, push state, then return from it
	task automatic t_single(input int l);
		src[l] <= 1'b1;
		cyc(3);
		cmp(ereq, 1);
		cmp(elvl, l);
		src[l] <= 1'b0;
		acc_en <= 1'b1;
		cyc(2);
		cmp(push, 1);
		cmp({insvc[l], latch[l]}, 2'b10);
		acc_en <= 1'b0;
		ret_req <= 1'b1;
		ret_lvl <= 4'(l);
		cyc(1);
		ret_req <= 1'b0;
		cmp({rvalid, insvc[l]}, 2'b10);
		cmp(raddr, 32'h5a000000 + l);
	endtask
	// Two levels raised together: the smaller number wins
	task automatic t_pair(input int a, input int b);
		src[a] <= 1'b1;
		src[b] <= 1'b1;
		cyc(3);
		cmp(ereq, 1);
		cmp(elvl, a);
		do_reset();
	endtask
	// Service level 10: only a strictly higher level is presented meanwhile
	task automatic t_nest();
		do_reset();
		src[10] <= 1'b1;
		cyc(3);
		acc_en <= 1'b1;
		cyc(2);
		acc_en <= 1'b0;
		cmp({push, insvc[10], latch[10]}, 3'b111);
		src[10] <= 1'b0;
		src[12] <= 1'b1;
		cyc(3);
		cmp(ereq, 0);
		src[12] <= 1'b0;
		src[9] <= 1'b1;
		cyc(3);
		cmp({ereq, elvl}, 5'h19);
		cv <= 1'b1;
		cbits <= 16'h1000;
		cyc(1);
		cv <= 1'b0;
		cmp(latch[12], 1);
	endtask
	task automatic t_mask();
		en_bits <= 16'hfdff;
		src[9] <= 1'b1;
		cyc(1);
		src[9] <= 1'b0;
		cyc(3);
		cmp({ereq, latch[9]}, 2'b01);
		cv <= 1'b1;
		cbits <= 16'h0200;
		cyc(1);
		cv <= 1'b0;
		cmp(latch[9], 0);
		en_bits <= 16'hffff;
		gie <= 1'b0;
		src[8] <= 1'b1;
		cyc(3);
		cmp({ereq, latch[8]}, 2'b01);
		gie <= 1'b1;
		cyc(3);
		cmp({ereq, elvl}, 5'h18);
	endtask
	////////////////////////////////////////
	initial begin
		#300000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		cyc(10);
		cmp({ereq, push, rvalid, elvl, latch}, 0);
		cmp(insvc, 0);
		cmp(raddr, 0);
		cyc(10);
		rst <= 1'b0;
		cyc(1);
		// Levels 14 and 15 stand in for software-raised interrupts here
		for (int l = 0; l < 16; l++) begin
			if (l != 4) begin
				t_single(l);
			end
		end
		cmp(latch[4], 0);
		t_pair(7, 15);
		t_pair(5, 6);
		t_pair(0, 3);
		t_pair(2, 14);
		t_mask();
		t_nest();
		wrap_up();
	end
endmodule // testbench
